// ### feature_regs_pkg.sv
// Constants shared by the serial feature register block
package feature_regs_pkg;
  localparam logic [7:0] ADDR_LOCK = 8'ha0;
  localparam logic [7:0] ADDR_CONFIG = 8'hb0;
  localparam logic [7:0] ADDR_STATUS = 8'hc0;
  localparam logic [7:0] OP_SET_FEATURE = 8'h1f;
  localparam logic [7:0] OP_GET_FEATURE = 8'h0f;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_PROGRAM_EXEC = 8'h10;
  localparam logic [7:0] OP_PROTECT_EXEC = 8'h2a;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_RESET = 8'hff;
  localparam logic [7:0] OP_RESET_ALT = 8'hfe;
  localparam int LOCK_FREEZE_BIT = 7;
  localparam int LOCK_RANGE_LSB = 3;
  localparam int LOCK_RANGE_W = 3;
  localparam int CFG_PARAM_ID_BIT = 6;
  localparam int CFG_ECC_BIT = 4;
  localparam int CFG_GUARD_BIT = 2;
  localparam int CFG_FAST_BIT = 1;
  localparam int CFG_HOLD_DIS_BIT = 0;
  localparam int ST_CORR_LSB = 4;
  localparam int ST_WRITE_FAIL_BIT = 3;
  localparam int ST_WIPE_FAIL_BIT = 2;
  localparam int ST_PERMIT_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam logic [7:0] LOCK_RESET = 8'h38;
  localparam logic [7:0] CONFIG_RESET = 8'h12;
  localparam logic [7:0] LOCK_WMASK = 8'hb8;
  localparam logic [7:0] CONFIG_WMASK = 8'h57;
  localparam logic [1:0] CORR_NONE = 2'h0;
  localparam logic [1:0] CORR_LOW = 2'h1;
  localparam logic [1:0] CORR_UNCORR = 2'h2;
  localparam logic [1:0] CORR_HIGH = 2'h3;
  localparam logic [1:0] ROW_LAST = 2'h2;
  localparam int PIN_W = 4;
  // Pin order {wp_n, cs_n, si, sck}; idle levels after reset
  localparam logic [3:0] PIN_IDLE = 4'hc;
endpackage : feature_regs_pkg

// ### pin_events_if.sv
// Synchronised serial pin levels and clock edge pulses
`timescale 1ns/10ps
interface pin_events_if;
  logic sck_rise;
  logic sck_fall;
  logic cs_n;
  logic si;
  logic wp_n;
  modport source (output sck_rise, output sck_fall, output cs_n, output si, output wp_n);
  modport sink (input sck_rise, input sck_fall, input cs_n, input si, input wp_n);
endinterface : pin_events_if

// ### pin_sync.sv
// Two-flop synchronisers for the serial pins and serial clock edge detection
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = feature_regs_pkg::PIN_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] pins,
  pin_events_if.source ev
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sync_t;
  sync_t st;
  sync_t next_st;

  always_comb
  begin
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= {3{feature_regs_pkg::PIN_IDLE[W-1:0]}};
    end
    else
    begin
      st <= next_st;
    end
  end

  // Edges come from the second and third stages only, never the first
  assign ev.sck_rise = st.s2[0] & ~st.s3[0];
  assign ev.sck_fall = ~st.s2[0] & st.s3[0];
  assign ev.si = st.s2[1];
  assign ev.cs_n = st.s2[2];
  assign ev.wp_n = st.s2[3];
endmodule : pin_sync

// ### byte_shifter.sv
// Serial byte shifter: input on clock rise, output on clock fall
`timescale 1ns/10ps
module byte_shifter (
  input wire logic clk,
  input wire logic arst_n,
  pin_events_if.sink ev,
  input wire logic [7:0] tx_byte,
  input wire logic tx_en,
  output logic byte_done,
  output logic [7:0] rx_byte,
  output logic so,
  output logic so_oe
);
  typedef struct packed {
    logic [2:0] cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic done;
    logic [7:0] held;
    logic so;
    logic oe;
  } shift_t;
  shift_t st;
  shift_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.oe = tx_en & ~ev.cs_n;
    if (ev.cs_n)
    begin
      next_st.cnt = 3'h0;
    end
    else if (ev.sck_rise)
    begin
      next_st.rx = {st.rx[6:0], ev.si};
      next_st.cnt = st.cnt + 3'h1;
      if (st.cnt == 3'h7)
      begin
        next_st.done = 1'b1;
        next_st.held = {st.rx[6:0], ev.si};
      end
    end
    else if (ev.sck_fall)
    begin
      // A fresh byte is taken at each byte boundary so live bits stay current
      if (st.cnt == 3'h0)
      begin
        next_st.so = tx_byte[7];
        next_st.tx = {tx_byte[6:0], 1'b0};
      end
      else
      begin
        next_st.so = st.tx[7];
        next_st.tx = {st.tx[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign byte_done = st.done;
  assign rx_byte = st.held;
  assign so = st.so;
  assign so_oe = st.oe;
endmodule : byte_shifter

// ### feature_regs.sv
// Lock, configuration and status feature bytes behind the serial command port
`timescale 1ns/10ps
module feature_regs (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  input wire logic core_busy,
  input wire logic write_fail_event,
  input wire logic wipe_fail_event,
  input wire logic read_done,
  input wire logic read_uncorrectable,
  input wire logic [3:0] read_flip_count,
  input wire logic [3:0] flip_threshold,
  output logic lock_freeze,
  output logic [2:0] lock_range,
  output logic param_id_read_mode,
  output logic ecc_enable,
  output logic permanent_guard_enable,
  output logic fast_page_read_enable,
  output logic hold_disable,
  output logic modify_permit_latch,
  output logic program_go,
  output logic protect_go,
  output logic erase_go,
  output logic abort_go,
  output logic [23:0] row_addr
);
  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DATA, PH_OUT, PH_ROW, PH_SKIP} phase_t;
  typedef struct packed {
    phase_t phase;
    logic [7:0] opcode;
    logic [7:0] addr;
    logic [7:0] lock;
    logic [7:0] cfg;
    logic permit;
    logic write_fail;
    logic wipe_fail;
    logic [1:0] corr;
    logic [1:0] row_cnt;
    logic [23:0] row;
    logic program_go;
    logic protect_go;
    logic erase_go;
    logic abort_go;
  } regs_t;

  regs_t st;
  regs_t next_st;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic [7:0] status_byte;
  logic frozen;
  logic cmd_byte;
  logic data_byte;

  pin_events_if ev ();

  pin_sync #(
    .W(feature_regs_pkg::PIN_W)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .pins({wp_n, cs_n, si, sck}),
    .ev(ev.source)
  );

  byte_shifter u_shift (
    .clk(clk),
    .arst_n(arst_n),
    .ev(ev.sink),
    .tx_byte(tx_byte),
    .tx_en(st.phase == PH_OUT),
    .byte_done(byte_done),
    .rx_byte(rx_byte),
    .so(so),
    .so_oe(so_oe)
  );

  assign cmd_byte = byte_done && !ev.cs_n && st.phase == PH_CMD;
  assign data_byte = byte_done && !ev.cs_n && st.phase == PH_DATA;
  assign frozen = !ev.wp_n && st.lock[feature_regs_pkg::LOCK_FREEZE_BIT];

  // Busy and fail bits are sampled whenever a byte goes out, so they stay live
  always_comb
  begin
    status_byte = '0;
    status_byte[feature_regs_pkg::ST_CORR_LSB +: 2] = st.corr;
    status_byte[feature_regs_pkg::ST_WRITE_FAIL_BIT] = st.write_fail;
    status_byte[feature_regs_pkg::ST_WIPE_FAIL_BIT] = st.wipe_fail;
    status_byte[feature_regs_pkg::ST_PERMIT_BIT] = st.permit;
    status_byte[feature_regs_pkg::ST_BUSY_BIT] = core_busy;
  end

  always_comb
  begin
    case (st.addr)
      feature_regs_pkg::ADDR_LOCK: tx_byte = st.lock;
      feature_regs_pkg::ADDR_CONFIG: tx_byte = st.cfg;
      feature_regs_pkg::ADDR_STATUS: tx_byte = status_byte;
      default: tx_byte = 8'h00;
    endcase
  end

  always_comb
  begin
    next_st = st;
    next_st.program_go = 1'b0;
    next_st.protect_go = 1'b0;
    next_st.erase_go = 1'b0;
    next_st.abort_go = 1'b0;
    if (ev.cs_n)
    begin
      next_st.phase = PH_CMD;
    end
    else if (byte_done)
    begin
      case (st.phase)
        PH_CMD:
        begin
          next_st.opcode = rx_byte;
          next_st.phase = PH_SKIP;
          next_st.row_cnt = 2'h0;
          case (rx_byte)
            feature_regs_pkg::OP_SET_FEATURE, feature_regs_pkg::OP_GET_FEATURE:
            begin
              next_st.phase = PH_ADDR;
            end
            feature_regs_pkg::OP_WRITE_ENABLE:
            begin
              next_st.permit = 1'b1;
            end
            feature_regs_pkg::OP_WRITE_DISABLE:
            begin
              next_st.permit = 1'b0;
            end
            feature_regs_pkg::OP_PROGRAM_EXEC, feature_regs_pkg::OP_BLOCK_ERASE:
            begin
              if (st.permit)
              begin
                next_st.phase = PH_ROW;
              end
            end
            feature_regs_pkg::OP_PROTECT_EXEC:
            begin
              if (st.permit && st.cfg[feature_regs_pkg::CFG_GUARD_BIT])
              begin
                next_st.phase = PH_ROW;
              end
            end
            feature_regs_pkg::OP_RESET, feature_regs_pkg::OP_RESET_ALT:
            begin
              // Aborts the core and clears the fail flags; stored settings are kept
              next_st.abort_go = 1'b1;
            end
            default:
            begin
              next_st.phase = PH_SKIP;
            end
          endcase
          // A feature read does not count as a new operation for the fail flags
          if (rx_byte != feature_regs_pkg::OP_GET_FEATURE
              && (next_st.phase != PH_SKIP || next_st.abort_go
              || rx_byte == feature_regs_pkg::OP_WRITE_ENABLE
              || rx_byte == feature_regs_pkg::OP_WRITE_DISABLE))
          begin
            next_st.write_fail = 1'b0;
            next_st.wipe_fail = 1'b0;
          end
        end
        PH_ADDR:
        begin
          next_st.addr = rx_byte;
          if (st.opcode == feature_regs_pkg::OP_GET_FEATURE)
          begin
            next_st.phase = PH_OUT;
          end
          else
          begin
            next_st.phase = PH_DATA;
          end
        end
        PH_DATA:
        begin
          next_st.phase = PH_SKIP;
          case (st.addr)
            feature_regs_pkg::ADDR_LOCK:
            begin
              if (!frozen)
              begin
                next_st.lock = (st.lock & ~feature_regs_pkg::LOCK_WMASK)
                  | (rx_byte & feature_regs_pkg::LOCK_WMASK);
              end
            end
            feature_regs_pkg::ADDR_CONFIG:
            begin
              next_st.cfg = (st.cfg & ~feature_regs_pkg::CONFIG_WMASK)
                | (rx_byte & feature_regs_pkg::CONFIG_WMASK);
            end
            default:
            begin
              // Status is read-only here, including the permit latch
              next_st.phase = PH_SKIP;
            end
          endcase
        end
        PH_ROW:
        begin
          next_st.row = {st.row[15:0], rx_byte};
          next_st.row_cnt = st.row_cnt + 2'h1;
          if (st.row_cnt == feature_regs_pkg::ROW_LAST)
          begin
            next_st.phase = PH_SKIP;
            next_st.program_go = st.opcode == feature_regs_pkg::OP_PROGRAM_EXEC;
            next_st.erase_go = st.opcode == feature_regs_pkg::OP_BLOCK_ERASE;
            next_st.protect_go = st.opcode == feature_regs_pkg::OP_PROTECT_EXEC;
          end
        end
        PH_OUT:
        begin
          next_st.phase = PH_OUT;
        end
        default:
        begin
          next_st.phase = PH_SKIP;
        end
      endcase
    end
    // Core events come after the command clear, so a coinciding failure is kept
    if (write_fail_event)
    begin
      next_st.write_fail = 1'b1;
    end
    if (wipe_fail_event)
    begin
      next_st.wipe_fail = 1'b1;
    end
    if (read_done && st.cfg[feature_regs_pkg::CFG_ECC_BIT])
    begin
      if (read_uncorrectable)
      begin
        next_st.corr = feature_regs_pkg::CORR_UNCORR;
      end
      else if (read_flip_count == 4'h0)
      begin
        next_st.corr = feature_regs_pkg::CORR_NONE;
      end
      else if (read_flip_count < flip_threshold)
      begin
        next_st.corr = feature_regs_pkg::CORR_LOW;
      end
      else
      begin
        next_st.corr = feature_regs_pkg::CORR_HIGH;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
      st.phase <= PH_CMD;
      st.lock <= feature_regs_pkg::LOCK_RESET;
      st.cfg <= feature_regs_pkg::CONFIG_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign lock_freeze = st.lock[feature_regs_pkg::LOCK_FREEZE_BIT];
  assign lock_range = st.lock[feature_regs_pkg::LOCK_RANGE_LSB +: 3];
  assign param_id_read_mode = st.cfg[feature_regs_pkg::CFG_PARAM_ID_BIT];
  assign ecc_enable = st.cfg[feature_regs_pkg::CFG_ECC_BIT];
  assign permanent_guard_enable = st.cfg[feature_regs_pkg::CFG_GUARD_BIT];
  assign fast_page_read_enable = st.cfg[feature_regs_pkg::CFG_FAST_BIT];
  assign hold_disable = st.cfg[feature_regs_pkg::CFG_HOLD_DIS_BIT];
  assign modify_permit_latch = st.permit;
  assign program_go = st.program_go;
  assign protect_go = st.protect_go;
  assign erase_go = st.erase_go;
  assign abort_go = st.abort_go;
  assign row_addr = st.row;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_freeze_blocks_lock: assert property (
    data_byte && st.addr == feature_regs_pkg::ADDR_LOCK && frozen |=> $stable(st.lock))
    else $error("lock written while frozen");
  a_lock_range_write: assert property (
    data_byte && st.addr == feature_regs_pkg::ADDR_LOCK && !frozen
    |=> lock_range == $past(rx_byte[feature_regs_pkg::LOCK_RANGE_LSB +: 3]))
    else $error("lock range not taken");
  a_permit_only_cmd: assert property ($changed(st.permit) |-> $past(cmd_byte)
    && ($past(rx_byte) == feature_regs_pkg::OP_WRITE_ENABLE
    || $past(rx_byte) == feature_regs_pkg::OP_WRITE_DISABLE))
    else $error("permit latch changed without command");
  a_permit_enable: assert property (
    cmd_byte && rx_byte == feature_regs_pkg::OP_WRITE_ENABLE |=> modify_permit_latch)
    else $error("enable command missed");
  a_erase_needs_permit: assert property (
    erase_go || program_go |-> $past(st.permit, 4)) else $error("operation without permit");
  a_guard_needs_enable: assert property (protect_go |-> permanent_guard_enable)
    else $error("guard command without enable");
  a_reserved_zero: assert property (
    (st.cfg & ~feature_regs_pkg::CONFIG_WMASK) == 8'h00
    && (st.lock & ~feature_regs_pkg::LOCK_WMASK) == 8'h00) else $error("reserved bit set");
  // The shifter copies the status byte at each byte start, so busy must be current there
  a_busy_live: assert property (
    st.phase == PH_OUT && st.addr == feature_regs_pkg::ADDR_STATUS && !ev.cs_n && ev.sck_fall
    && u_shift.st.cnt == 3'h0
    |=> u_shift.st.tx[feature_regs_pkg::ST_BUSY_BIT + 1] == $past(core_busy))
    else $error("busy bit stale");
  a_fail_sticky: assert property (st.write_fail && !cmd_byte |=> st.write_fail)
    else $error("program fail flag lost");
  a_fail_set_wins: assert property (write_fail_event |=> st.write_fail)
    else $error("program fail event lost");
  a_read_repeats: assert property (
    st.phase == PH_OUT && !ev.cs_n |=> st.phase == PH_OUT) else $error("feature read stopped");
  a_reset_keeps_cfg: assert property (abort_go |-> st.cfg == $past(st.cfg, 1))
    else $error("settings lost on reset command");
  a_uncorr_code: assert property (
    read_done && ecc_enable && read_uncorrectable |=> st.corr == feature_regs_pkg::CORR_UNCORR)
    else $error("wrong correction code");

  c_feature_read: cover property (st.phase == PH_OUT ##1 so_oe);
  c_erase: cover property (erase_go);
  c_lock_write: cover property (data_byte && st.addr == feature_regs_pkg::ADDR_LOCK);
  c_guard: cover property (protect_go);
endmodule : feature_regs

// ### host_model.sv
// Host controller model that frames commands on the serial feature port
`timescale 1ns/10ps
module host_model (
  input wire logic clk,
  input wire logic so,
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic wp_n
);
  // Serial clock rests low between frames; every change lands on a falling clk edge
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    wp_n = 1'b1;
  end

  task automatic set_wp(input logic lvl);
    @(negedge clk);
    wp_n = lvl;
  endtask : set_wp

  // Latch is only altered by 06h/04h frames; no quad loads are ever issued
  task automatic start();
    @(negedge clk);
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
  endtask : start

  // Mode 0: si set while sck is low, both sides sample on the rise; 4 clk per phase
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      si = tx[i];
      repeat (4) @(negedge clk);
      sck = 1'b1;
      rx[i] = so;
      repeat (4) @(negedge clk);
      sck = 1'b0;
    end
  endtask : xfer

  // Raising cs_n ends a repeated read; si flips so a stale level never passes for data
  task automatic stop();
    repeat (2) @(negedge clk);
    cs_n = 1'b1;
    si = ~si;
    repeat (6) @(negedge clk);
  endtask : stop
endmodule : host_model

// ### serial_nand_feature_registers_bench.sv
// Self-checking bench for the serial feature register block
`timescale 1ns/10ps
module serial_nand_feature_registers_bench;
  localparam logic [7:0] LK = feature_regs_pkg::ADDR_LOCK;
  localparam logic [7:0] CF = feature_regs_pkg::ADDR_CONFIG;
  localparam logic [7:0] ST = feature_regs_pkg::ADDR_STATUS;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic core_busy = 1'b0;
  logic wr_fail = 1'b0;
  logic wipe_fail = 1'b0;
  logic rd_done = 1'b0;
  logic rd_unc = 1'b0;
  logic [3:0] flips = 4'h0;
  logic [3:0] thresh = 4'h4;
  logic sck, cs_n, si, wp_n, so, so_oe, freeze, idr, ecc, guard, fast, hold, permit;
  logic prog_go, prot_go, ers_go, abrt_go;
  logic [2:0] range;
  logic [23:0] row;
  logic [7:0] v;
  logic [3:0] cnt_t [4] = '{4'h3, 4'h4, 4'h0, 4'h0};
  logic unc_t [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  logic [1:0] corr_t [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  int n_prog = 0;
  int n_prot = 0;
  int n_ers = 0;
  int n_abort = 0;

  always #12.5 clk = ~clk;

  host_model host (.clk(clk), .so(so), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n));

  feature_regs dut (
    .clk(clk), .arst_n(arst_n), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .so(so), .so_oe(so_oe), .core_busy(core_busy), .write_fail_event(wr_fail),
    .wipe_fail_event(wipe_fail), .read_done(rd_done), .read_uncorrectable(rd_unc),
    .read_flip_count(flips), .flip_threshold(thresh), .lock_freeze(freeze),
    .lock_range(range), .param_id_read_mode(idr), .ecc_enable(ecc),
    .permanent_guard_enable(guard), .fast_page_read_enable(fast),
    .hold_disable(hold), .modify_permit_latch(permit), .program_go(prog_go),
    .protect_go(prot_go), .erase_go(ers_go), .abort_go(abrt_go), .row_addr(row)
  );

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // Ceiling is about three times the expected run length
  // Pulses are counted mid-cycle so the edge that launches them cannot race the count
  always @(negedge clk)
  begin
    cycles++;
    if (prog_go === 1'b1)
      n_prog++;
    if (prot_go === 1'b1)
      n_prot++;
    if (ers_go === 1'b1)
      n_ers++;
    if (abrt_go === 1'b1)
      n_abort++;
    if (cycles == 40000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic set_feat(input logic [7:0] a, input logic [7:0] d);
    host.start();
    host.xfer(feature_regs_pkg::OP_SET_FEATURE, v);
    host.xfer(a, v);
    host.xfer(d, v);
    host.stop();
  endtask : set_feat

  task automatic get_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
    host.start();
    host.xfer(feature_regs_pkg::OP_GET_FEATURE, v);
    host.xfer(a, v);
    host.xfer(8'h5a, v);
    host.stop();
    check(what, exp, v);
  endtask : get_reg

  task automatic cmd(input logic [7:0] op);
    host.start();
    host.xfer(op, v);
    host.stop();
  endtask : cmd

  task automatic row_cmd(input logic [7:0] op, input logic [23:0] r);
    host.start();
    host.xfer(op, v);
    host.xfer(r[23:16], v);
    host.xfer(r[15:8], v);
    host.xfer(r[7:0], v);
    host.stop();
  endtask : row_cmd

  // One-cycle pulses from the array core, with their qualifiers
  task automatic core_pulse(input logic rd, input logic unc, input logic [3:0] n,
                            input logic wf, input logic ef);
    @(negedge clk);
    rd_done = rd;
    rd_unc = unc;
    flips = n;
    wr_fail = wf;
    wipe_fail = ef;
    @(negedge clk);
    rd_done = 1'b0;
    wr_fail = 1'b0;
    wipe_fail = 1'b0;
  endtask : core_pulse

  initial
  begin
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    get_reg(LK, 8'h38, "lock reset");
    get_reg(CF, 8'h12, "config reset");
    get_reg(ST, 8'h00, "status reset");
    check("lock outputs", 4'h7, {freeze, range});
    set_feat(CF, 8'hff);
    get_reg(CF, 8'h57, "config reserved");
    check("config outputs", 5'h1f, {idr, ecc, guard, fast, hold});
    set_feat(CF, 8'h00);
    get_reg(CF, 8'h00, "config clear");
    check("config off", 5'h00, {idr, ecc, guard, fast, hold});
    set_feat(CF, 8'h10);
    for (int c = 0; c < 8; c++)
    begin
      set_feat(LK, 8'(c << 3));
      get_reg(LK, 8'(c << 3), "lock range");
      check("range out", c, {29'h0, range});
    end
    set_feat(LK, 8'hff);
    get_reg(LK, 8'hb8, "lock write");
    host.set_wp(1'b0);
    set_feat(LK, 8'h00);
    get_reg(LK, 8'hb8, "lock frozen");
    check("freeze out", 4'hf, {freeze, range});
    host.set_wp(1'b1);
    set_feat(LK, 8'h00);
    get_reg(LK, 8'h00, "lock unfrozen");
    set_feat(ST, 8'hff);
    get_reg(ST, 8'h00, "status write");
    cmd(feature_regs_pkg::OP_WRITE_ENABLE);
    get_reg(ST, 8'h02, "latch set");
    cmd(feature_regs_pkg::OP_RESET);
    get_reg(CF, 8'h10, "config kept");
    check("abort pulses", 1, n_abort);
    cmd(feature_regs_pkg::OP_RESET_ALT);
    get_reg(LK, 8'h00, "lock kept");
    check("abort pulses alt", 2, n_abort);
    cmd(feature_regs_pkg::OP_WRITE_DISABLE);
    get_reg(ST, 8'h00, "latch clear");
    // Live bits are sampled as each byte starts, so the byte straddling a change is skipped
    host.start();
    host.xfer(feature_regs_pkg::OP_GET_FEATURE, v);
    host.xfer(ST, v);
    host.xfer(8'h5a, v);
    check("status first", 8'h00, v);
    @(negedge clk);
    core_busy = 1'b1;
    host.xfer(8'h5a, v);
    host.xfer(8'h5a, v);
    check("status busy", 8'h01, v);
    core_busy = 1'b0;
    core_pulse(1'b0, 1'b0, 4'h0, 1'b1, 1'b0);
    host.xfer(8'h5a, v);
    host.xfer(8'h5a, v);
    check("status fail", 8'h08, v);
    check("output driven", 1'b1, so_oe);
    host.stop();
    check("output released", 1'b0, so_oe);
    get_reg(ST, 8'h08, "fail held");
    cmd(feature_regs_pkg::OP_WRITE_ENABLE);
    get_reg(ST, 8'h02, "fail cleared");
    core_pulse(1'b0, 1'b0, 4'h0, 1'b0, 1'b1);
    get_reg(ST, 8'h06, "erase fail");
    cmd(feature_regs_pkg::OP_WRITE_DISABLE);
    row_cmd(feature_regs_pkg::OP_BLOCK_ERASE, 24'h010203);
    row_cmd(feature_regs_pkg::OP_PROGRAM_EXEC, 24'h010203);
    check("refused ops", 0, n_ers + n_prog);
    cmd(feature_regs_pkg::OP_WRITE_ENABLE);
    row_cmd(feature_regs_pkg::OP_BLOCK_ERASE, 24'h010203);
    check("erase pulses", 1, n_ers);
    check("erase row", 24'h010203, row);
    row_cmd(feature_regs_pkg::OP_PROGRAM_EXEC, 24'h040506);
    check("program pulses", 1, n_prog);
    row_cmd(feature_regs_pkg::OP_PROTECT_EXEC, 24'h070809);
    check("guard off", 0, n_prot);
    set_feat(CF, 8'h14);
    row_cmd(feature_regs_pkg::OP_PROTECT_EXEC, 24'h070809);
    check("guard on", 1, n_prot);
    for (int k = 0; k < 4; k++)
    begin
      core_pulse(1'b1, unc_t[k], cnt_t[k], 1'b0, 1'b0);
      get_reg(ST, {2'h0, corr_t[k], 4'h2}, "status read");
      check("correction", corr_t[k], v[5:4]);
    end
    // A lower threshold turns the same flip count into the high code
    thresh = 4'h3;
    core_pulse(1'b1, 1'b0, 4'h3, 1'b0, 1'b0);
    get_reg(ST, 8'h32, "status threshold");
    check("threshold code", 2'h3, v[5:4]);
    set_feat(CF, 8'h00);
    core_pulse(1'b1, 1'b1, 4'h0, 1'b0, 1'b0);
    get_reg(ST, 8'h32, "status ecc off");
    check("ecc off", 2'h3, v[5:4]);
    report_and_stop();
  end
endmodule : serial_nand_feature_registers_bench
